// ==== include/lift_seq_pkg.sv ====
// Constants, register map and state codes of the lift end-position sequencer
package lift_seq_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00; // Mode and command bits
	localparam logic [7:0] MAIN_OFS = 8'h04; // Main speed setpoint
	localparam logic [7:0] HIGH_OFS = 8'h08; // High speed setpoint
	localparam logic [7:0] LOW_OFS = 8'h0c; // Low speed setpoint
	localparam logic [7:0] STAT_OFS = 8'h10; // Read-only status
	// ****************************************
	// Control field positions
	// ****************************************
	localparam int APP_LSB = 0; // application_select, 4 bits
	localparam int SHUT_BIT = 4; // end_position_shutdown_en
	localparam int BYP_BIT = 5; // sensor_bypass
	localparam int DIR_BIT = 6; // direction_select
	localparam int ON_BIT = 7; // ON command level
	localparam int STOPT_LSB = 8; // stop_sensor_eval_type, 3 bits
	localparam int SLOWT_LSB = 12; // slow_sensor_eval_type, 3 bits
	localparam logic [31:0] CTRL_MASK = 32'h0000_77ff; // Writable bits
	localparam logic [31:0] CTRL_RST = 32'h0000_1119; // Lift, shutdown on, level
	localparam logic [31:0] SPEED_RST = 32'h0000_0000; // Setpoints after reset
	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [3:0] APP_ONE = 4'h9; // Two positions, one speed
	localparam logic [3:0] APP_TWO = 4'ha; // Two positions, two speeds
	localparam logic [2:0] EVAL_HIGH = 3'h1; // High level
	localparam logic [2:0] EVAL_LOW = 3'h2; // Low level
	localparam logic [2:0] EVAL_RISE = 3'h3; // Rising edge
	localparam logic [2:0] EVAL_FALL = 3'h4; // Falling edge
	localparam int SNS_STOP_POS = 0; // Sensor index order
	localparam int SNS_STOP_NEG = 1;
	localparam int SNS_SLOW_POS = 2;
	localparam int SNS_SLOW_NEG = 3;
	typedef enum logic [4:0] {
		S_IDLE = 5'h01, // Motor off, waiting for ON
		S_RUN_HIGH = 5'h02, // Main or high speed
		S_RUN_LOW = 5'h04, // Low speed
		S_HELD = 5'h08, // Level stop, restarts by itself
		S_LATCHED = 5'h10 // Stopped until ON drops
	} seq_state_t;
endpackage

// ==== hw/lift_end_position_sequencer.sv ====
// Lift end-position sequencer with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
// Summary of operation
// - Selector 9: one speed, two stop sensors
// - Selector 10: two speeds, four sensors
// - One speed: ON runs at main setpoint
// - Two speeds: ON runs at high setpoint
// - Direction select 0 positive, 1 negative
// - No shutdown: any stop sensor stops
// - No shutdown: any slow sensor slows
// - Slow sensors use their own evaluation type
// - Level type, no shutdown: auto restart
// - Edge type: stay stopped until new ON
// - No shutdown, bypass: ignore all sensors
// - Shutdown, positive travel: positive stop only
// - Shutdown, negative travel: negative stop only
// - Shutdown, two speeds: own-direction sensors only
// - After end stop: new ON, opposite direction
// - Shutdown: bypass does not mask sensors
// - Shutdown, level: stop stays latched
// - Shutdown, level: low speed stays latched
module lift_end_position_sequencer #(
	parameter int ADDR_W = 8, // Decoded address bits
	parameter int SPEED_W = 16 // Setpoint width
) (
	input wire logic hclk, // Bus and system clock
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [ADDR_W-1:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready in
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready out
	output logic hresp, // Always OKAY
	input wire logic stop_sensor_pos, // Stop sensor, positive end
	input wire logic stop_sensor_neg, // Stop sensor, negative end
	input wire logic slow_sensor_pos, // Low-speed sensor, positive
	input wire logic slow_sensor_neg, // Low-speed sensor, negative
	output logic run_enable, // Ramp generator may run
	output logic normal_stop_ramp, // Ramp down to standstill
	output logic [SPEED_W-1:0] speed_setpoint, // Target speed
	output logic direction_neg // High for negative travel
);
	import lift_seq_pkg::*;

	// ****************************************
	// Elaboration check
	// ****************************************
	if (SPEED_W < 1 || SPEED_W > 32 || ADDR_W < 8) begin : g_bad_param
		$error("lift sequencer: SPEED_W must be 1..32 and ADDR_W at least 8");
	end

	// ****************************************
	// Register storage
	// ****************************************
	logic [31:0] ctrl; // Control word
	logic [SPEED_W-1:0] main_speed_setpoint; // One-speed target
	logic [SPEED_W-1:0] high_speed_setpoint; // Two-speed fast target
	logic [SPEED_W-1:0] low_speed_setpoint; // Two-speed slow target
	logic wr_pend; // Write data phase pending
	logic [7:0] wr_addr; // Address of pending write
	logic rd_pend; // Read wait cycle pending
	logic [7:0] rd_addr; // Address of pending read

	// ****************************************
	// Control fields
	// ****************************************
	wire [3:0] application_select = ctrl[APP_LSB+:4];
	wire end_position_shutdown_en = ctrl[SHUT_BIT];
	wire sensor_bypass = ctrl[BYP_BIT];
	wire direction_select = ctrl[DIR_BIT];
	wire on_cmd = ctrl[ON_BIT];
	wire [2:0] stop_sensor_eval_type = ctrl[STOPT_LSB+:3];
	wire [2:0] slow_sensor_eval_type = ctrl[SLOWT_LSB+:3];
	wire mode_one = (application_select == APP_ONE);
	wire mode_two = (application_select == APP_TWO);
	wire mode_ok = mode_one | mode_two;

	// ****************************************
	// AHB-Lite decode
	// ****************************************
	wire addr_take = hsel & hready & htrans[1]; // Nonseq or seq phase
	wire word_ok = (hsize == 3'h2); // Only whole-word writes act; reads of any size are taken
	wire wr_take = addr_take & hwrite & word_ok;
	wire rd_take = addr_take & ~hwrite;
	wire [7:0] haddr_lo = haddr[7:0];
	wire hi_zero = (haddr >> 8) == '0; // Aliases above 8 bits unmapped
	wire [31:0] stat_word;
	wire [31:0] rd_mux = (rd_addr == CTRL_OFS) ? ctrl :
		(rd_addr == MAIN_OFS) ? 32'(main_speed_setpoint) :
		(rd_addr == HIGH_OFS) ? 32'(high_speed_setpoint) :
		(rd_addr == LOW_OFS) ? 32'(low_speed_setpoint) :
		(rd_addr == STAT_OFS) ? stat_word : 32'h0000_0000;

	// Address phase capture; reads take one wait state so data is a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			rd_pend <= 1'b0;
			rd_addr <= 8'h00;
		end else begin
			wr_pend <= wr_take & hi_zero;
			wr_addr <= haddr_lo;
			rd_pend <= rd_take;
			rd_addr <= hi_zero ? haddr_lo : 8'hff;
		end
	end

	// Read answer and ready; response is never an error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= ~rd_take; // Low for the one wait cycle
			hresp <= 1'b0;
			if (rd_pend) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Register writes in the data phase; status and unmapped ignore writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= CTRL_RST;
			main_speed_setpoint <= SPEED_RST[SPEED_W-1:0];
			high_speed_setpoint <= SPEED_RST[SPEED_W-1:0];
			low_speed_setpoint <= SPEED_RST[SPEED_W-1:0];
		end else if (wr_pend) begin
			if (wr_addr == CTRL_OFS) ctrl <= hwdata & CTRL_MASK;
			if (wr_addr == MAIN_OFS) main_speed_setpoint <= hwdata[SPEED_W-1:0];
			if (wr_addr == HIGH_OFS) high_speed_setpoint <= hwdata[SPEED_W-1:0];
			if (wr_addr == LOW_OFS) low_speed_setpoint <= hwdata[SPEED_W-1:0];
		end
	end

	// ****************************************
	// Sensor synchronisers and evaluation
	// ****************************************
	wire [3:0] sns_pin = {slow_sensor_neg, slow_sensor_pos, stop_sensor_neg, stop_sensor_pos};
	logic [3:0] sns_meta; // First stage, read by second only
	logic [3:0] sns_sync; // Safe level
	logic [3:0] sns_prev; // Level one cycle earlier
	logic [3:0] trig; // Evaluated trigger per sensor

	for (genvar i = 0; i < 4; i++) begin : g_sns
		// Stop sensors share one type, slow sensors the other
		wire [2:0] etype = (i < 2) ? stop_sensor_eval_type : slow_sensor_eval_type;
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				sns_meta[i] <= 1'b0;
				sns_sync[i] <= 1'b0;
				sns_prev[i] <= 1'b0;
			end else begin
				sns_meta[i] <= sns_pin[i];
				sns_sync[i] <= sns_meta[i];
				sns_prev[i] <= sns_sync[i];
			end
		end
		// Unlisted codes never trigger, so the lift cannot be stopped by them
		assign trig[i] = (etype == EVAL_HIGH) ? sns_sync[i] :
			(etype == EVAL_LOW) ? ~sns_sync[i] :
			(etype == EVAL_RISE) ? (sns_sync[i] & ~sns_prev[i]) :
			(etype == EVAL_FALL) ? (~sns_sync[i] & sns_prev[i]) : 1'b0;
	end

	// ****************************************
	// Sensor selection
	// ****************************************
	seq_state_t state; // Sequencer state
	seq_state_t next_state;
	logic cur_dir; // Direction of the present run
	logic last_dir; // Direction of the last end stop
	logic blocked; // Same direction refused after end stop
	logic on_prev; // ON level one cycle earlier
	wire on_rise = on_cmd & ~on_prev; // Fresh ON command
	// Shutdown picks the sensor of the travel direction and ignores bypass
	wire stop_dir = cur_dir ? trig[SNS_STOP_NEG] : trig[SNS_STOP_POS];
	wire slow_dir = cur_dir ? trig[SNS_SLOW_NEG] : trig[SNS_SLOW_POS];
	wire stop_any = trig[SNS_STOP_POS] | trig[SNS_STOP_NEG];
	wire slow_any = trig[SNS_SLOW_POS] | trig[SNS_SLOW_NEG];
	wire stop_hit = end_position_shutdown_en ? stop_dir :
		(~sensor_bypass & stop_any);
	wire slow_hit = mode_two & (end_position_shutdown_en ? slow_dir :
		(~sensor_bypass & slow_any));
	wire stop_edge = (stop_sensor_eval_type == EVAL_RISE) |
		(stop_sensor_eval_type == EVAL_FALL);
	wire slow_level = (slow_sensor_eval_type == EVAL_HIGH) |
		(slow_sensor_eval_type == EVAL_LOW);
	// Shutdown or edge evaluation keeps the motor down after a stop
	wire stop_latch = end_position_shutdown_en | stop_edge;
	// After an end stop only the opposite direction may start
	wire dir_refused = blocked & (direction_select == last_dir);
	wire start = on_rise & mode_ok & ~dir_refused;
	// Stop target carries the full state code, not a single bit
	seq_state_t stop_to;
	assign stop_to = stop_latch ? S_LATCHED : S_HELD;
	wire is_run = (state == S_RUN_HIGH) | (state == S_RUN_LOW);
	assign stat_word = {19'h0, is_run, sns_sync, last_dir, blocked, cur_dir, state};

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: begin
				if (start) next_state = S_RUN_HIGH;
			end
			S_RUN_HIGH: begin
				if (stop_hit) next_state = seq_state_t'(stop_to);
				else if (slow_hit) next_state = S_RUN_LOW;
			end
			S_RUN_LOW: begin
				// With shutdown the slow state holds after the level goes
				if (stop_hit) next_state = seq_state_t'(stop_to);
				else if (!end_position_shutdown_en && slow_level && !slow_hit)
					next_state = S_RUN_HIGH;
			end
			S_HELD: begin
				if (!stop_hit) next_state = slow_hit ? S_RUN_LOW : S_RUN_HIGH;
			end
			S_LATCHED: begin
				next_state = S_LATCHED;
			end
		endcase
		// Dropping ON or leaving the lift modes always ends the run
		if (!on_cmd || !mode_ok) next_state = S_IDLE;
	end

	// ****************************************
	// State and direction registers
	// ****************************************
	wire end_stop = is_run & stop_hit & end_position_shutdown_en & on_cmd & mode_ok;

	// State, ON edge memory and direction bookkeeping
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= S_IDLE;
			on_prev <= 1'b0;
			cur_dir <= 1'b0;
			last_dir <= 1'b0;
			blocked <= 1'b0;
		end else begin
			state <= next_state;
			on_prev <= on_cmd;
			if (state == S_IDLE && start) begin
				cur_dir <= direction_select;
				blocked <= 1'b0;
			end else if (end_stop) begin
				last_dir <= cur_dir;
				blocked <= 1'b1;
			end
		end
	end

	// ****************************************
	// Motor outputs
	// ****************************************
	wire next_run = (state == S_RUN_HIGH) | (state == S_RUN_LOW);
	wire [SPEED_W-1:0] run_speed = mode_two ? high_speed_setpoint : main_speed_setpoint;
	wire [SPEED_W-1:0] next_speed = (state == S_RUN_LOW) ? low_speed_setpoint :
		(state == S_RUN_HIGH) ? run_speed : '0;

	// Outputs lag the state by one cycle; the ramp generator shapes speed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_enable <= 1'b0;
			normal_stop_ramp <= 1'b1;
			speed_setpoint <= '0;
			direction_neg <= 1'b0;
		end else begin
			run_enable <= next_run;
			normal_stop_ramp <= ~next_run;
			speed_setpoint <= next_speed;
			direction_neg <= cur_dir;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_one_speed_value: assert property (
		(state == S_RUN_HIGH && mode_one) |=> speed_setpoint == $past(main_speed_setpoint))
		else $error("one-speed run not at main setpoint");
	chk_two_speed_value: assert property (
		(state == S_RUN_HIGH && mode_two) |=> speed_setpoint == $past(high_speed_setpoint))
		else $error("two-speed run not at high setpoint");
	chk_start_dir: assert property (
		(state == S_IDLE && start) |=> ##1 direction_neg == $past(direction_select, 2))
		else $error("direction output does not follow select");
	chk_stop_any: assert property (
		(is_run && stop_hit && on_cmd && mode_ok) |=> ##1 !run_enable && normal_stop_ramp)
		else $error("stop sensor did not stop motor");
	chk_slow_down: assert property (
		(state == S_RUN_HIGH && !stop_hit && slow_hit && on_cmd && mode_ok)
		|=> ##1 speed_setpoint == $past(low_speed_setpoint))
		else $error("slow sensor did not select low speed");
	chk_auto_restart: assert property (
		(state == S_HELD && !stop_hit && !slow_hit && on_cmd && mode_ok) |=> state == S_RUN_HIGH)
		else $error("level stop did not restart");
	chk_latch_hold: assert property (
		(state == S_LATCHED && on_cmd && mode_ok) |=> state == S_LATCHED)
		else $error("latched stop left without new ON");
	chk_bypass_ignore: assert property (
		(!end_position_shutdown_en && sensor_bypass) |-> !stop_hit && !slow_hit)
		else $error("bypass did not mask sensors");
	chk_shut_pos_only: assert property (
		(end_position_shutdown_en && !cur_dir) |-> stop_hit == trig[SNS_STOP_POS])
		else $error("positive travel used wrong stop sensor");
	chk_shut_neg_only: assert property (
		(end_position_shutdown_en && cur_dir) |-> stop_hit == trig[SNS_STOP_NEG])
		else $error("negative travel used wrong stop sensor");
	chk_shut_slow_dir: assert property (
		(state == S_RUN_HIGH && end_position_shutdown_en && !stop_dir && !slow_dir
		&& on_cmd && mode_ok) |=> state == S_RUN_HIGH)
		else $error("other-direction sensor changed the run");
	chk_opposite_only: assert property (
		(state == S_IDLE && dir_refused) |=> state == S_IDLE)
		else $error("restart allowed in blocked direction");
	chk_slow_latched: assert property (
		(state == S_RUN_LOW && end_position_shutdown_en && !stop_hit && on_cmd && mode_ok)
		|=> state == S_RUN_LOW)
		else $error("low speed not held under shutdown");
	chk_ramp_pair: assert property (
		run_enable != normal_stop_ramp)
		else $error("run and stop ramp outputs disagree");

	cov_low_speed: cover property (state == S_RUN_HIGH ##1 state == S_RUN_LOW);
	cov_held_restart: cover property (state == S_HELD ##1 state == S_RUN_HIGH);
	cov_end_stop: cover property (end_stop ##1 state == S_LATCHED);
	cov_reverse: cover property (blocked && state == S_IDLE && start);

endmodule // lift_end_position_sequencer

// ==== sim/lift_partner.sv ====
// Behavioural lift carriage with cam sensors, plus manual sensor takeover
`timescale 1ns/10ps
module lift_partner #(
	parameter int LIM = 40, // Stop cam distance from start point
	parameter int SLW = 12 // Low-speed cam lead before stop cam
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic run_enable, // Ramp generator may run
	input wire logic direction_neg, // Negative travel
	input wire logic man_en, // Bench drives sensors itself
	input wire logic [3:0] man_lvl, // {slow_neg,slow_pos,stop_neg,stop_pos}
	output logic stop_sensor_pos, // Stop cam, positive end
	output logic stop_sensor_neg, // Stop cam, negative end
	output logic slow_sensor_pos, // Low-speed cam, positive end
	output logic slow_sensor_neg // Low-speed cam, negative end
);
	int pos; // Carriage position, one step per running cycle
	// ****************************************
	// Travel
	// ****************************************
	// Moves only while enabled, so overshoot shows as cam still lit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos <= 0;
		end else if (run_enable) begin
			pos <= direction_neg ? pos - 1 : pos + 1;
		end
	end
	// Low-speed cam is longer than the stop cam, both ends
	assign stop_sensor_pos = man_en ? man_lvl[0] : (pos >= LIM);
	assign stop_sensor_neg = man_en ? man_lvl[1] : (pos <= -LIM);
	assign slow_sensor_pos = man_en ? man_lvl[2] : (pos >= LIM - SLW);
	assign slow_sensor_neg = man_en ? man_lvl[3] : (pos <= SLW - LIM);
endmodule // lift_partner

// ==== sim/lift_end_position_sequencer_bench.sv ====
// Self-checking bench for the lift end-position sequencer
`timescale 1ns/10ps
module lift_end_position_sequencer_bench;
	import lift_seq_pkg::*;
	localparam logic [15:0] MAIN = 16'h0123; // Main setpoint
	localparam logic [15:0] HIGH = 16'h0456; // High setpoint
	localparam logic [15:0] LOW = 16'h0078; // Low setpoint
	logic hclk, hresetn, hsel, hwrite, man_en;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic hreadyout, hresp, run_enable, normal_stop_ramp, direction_neg;
	logic [15:0] speed_setpoint;
	logic stop_sensor_pos, stop_sensor_neg, slow_sensor_pos, slow_sensor_neg;
	logic [3:0] man_lvl; // Manual sensor levels
	int err_total, comparisons;
	lift_end_position_sequencer u_lift_end_position_sequencer (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .stop_sensor_pos(stop_sensor_pos), .stop_sensor_neg(stop_sensor_neg),
		.slow_sensor_pos(slow_sensor_pos), .slow_sensor_neg(slow_sensor_neg),
		.run_enable(run_enable), .normal_stop_ramp(normal_stop_ramp),
		.speed_setpoint(speed_setpoint), .direction_neg(direction_neg));
	lift_partner u_lift_partner (.hclk(hclk), .hresetn(hresetn), .run_enable(run_enable),
		.direction_neg(direction_neg), .man_en(man_en), .man_lvl(man_lvl),
		.stop_sensor_pos(stop_sensor_pos), .stop_sensor_neg(stop_sensor_neg),
		.slow_sensor_pos(slow_sensor_pos), .slow_sensor_neg(slow_sensor_neg));
	// ****************************************
	// Bus and check helpers
	// ****************************************
	// Control word: app, shutdown, bypass, direction, ON, stop type, slow type
	function automatic logic [31:0] ctrl(logic [3:0] a, logic sh, logic by, logic dr, logic on,
		logic [2:0] st, logic [2:0] sl);
		return {17'h0, sl, 1'b0, st, on, dr, by, sh, a};
	endfunction
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic cw(input logic [31:0] d);
		ahb(CTRL_OFS, 1'b1, d);
		repeat (6) @(posedge hclk);
	endtask
	// Fresh ON: stored bit goes low, then high
	task automatic fresh(input logic [31:0] c);
		cw(c & ~(32'h1 << ON_BIT));
		cw(c | (32'h1 << ON_BIT));
	endtask
	// Sensor change, then room for sync, state and output stages
	task automatic sns(input logic [3:0] v);
		man_lvl <= v;
		repeat (6) @(posedge hclk);
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	// Direction only matters while the motor runs
	task automatic chk_mot(input logic r, input logic [15:0] s, input logic d);
		comparisons++;
		if (run_enable !== r || normal_stop_ramp !== ~r || speed_setpoint !== s
			|| (r && direction_neg !== d)) begin
			err_total++;
			$display("ERROR %0t motor %b %h %b", $time, run_enable, speed_setpoint, direction_neg);
		end
	endtask
	task automatic wait_spd(input logic [15:0] s);
		int n;
		n = 0;
		while (speed_setpoint !== s && n < 200) begin
			@(posedge hclk);
			n++;
		end
	endtask
	task automatic end_of_test();
		$display("counts: %0d compared, %0d mismatched", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// Clock, reset, timeout
	// ****************************************
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		err_total++;
		end_of_test();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk_mot(1'b0, 16'h0, 1'b0);
		ahb(CTRL_OFS, 1'b0, 32'h0);
		chk_word(rd, CTRL_RST);
		ahb(8'h14, 1'b0, 32'h0);
		chk_word(rd, 32'h0);
		ahb(MAIN_OFS, 1'b1, {16'h0, MAIN});
		ahb(HIGH_OFS, 1'b1, {16'h0, HIGH});
		ahb(LOW_OFS, 1'b1, {16'h0, LOW});
		ahb(LOW_OFS, 1'b0, 32'h0);
		chk_word(rd, {16'h0, LOW});
		chk_word({31'h0, hresp}, 32'h0);
		cw(32'hffff_ffff);
		ahb(CTRL_OFS, 1'b0, 32'h0);
		chk_word(rd, CTRL_MASK);
		chk_mot(1'b0, 16'h0, 1'b0);
		cw(32'h0);
		$display("test reset done");
	endtask
	// Carriage really travels to the negative cams
	task automatic t_motion();
		cw(ctrl(APP_TWO, 1'b1, 1'b0, 1'b1, 1'b1, EVAL_HIGH, EVAL_HIGH));
		chk_mot(1'b1, HIGH, 1'b1);
		wait_spd(LOW);
		chk_mot(1'b1, LOW, 1'b1);
		wait_spd(16'h0);
		chk_mot(1'b0, 16'h0, 1'b1);
		man_en <= 1'b1;
		sns(4'h0);
		chk_mot(1'b0, 16'h0, 1'b1);
		ahb(STAT_OFS, 1'b0, 32'h0);
		chk_word(rd, 32'h0000_00f0);
		$display("test motion done");
	endtask
	task automatic t_one_shut();
		fresh(ctrl(APP_ONE, 1'b1, 1'b1, 1'b0, 1'b1, EVAL_HIGH, EVAL_HIGH));
		chk_mot(1'b1, MAIN, 1'b0);
		sns(4'h2);
		chk_mot(1'b1, MAIN, 1'b0);
		sns(4'h1);
		chk_mot(1'b0, 16'h0, 1'b0);
		sns(4'h0);
		chk_mot(1'b0, 16'h0, 1'b0);
		fresh(ctrl(APP_ONE, 1'b1, 1'b1, 1'b0, 1'b1, EVAL_HIGH, EVAL_HIGH));
		chk_mot(1'b0, 16'h0, 1'b0);
		fresh(ctrl(APP_ONE, 1'b1, 1'b1, 1'b1, 1'b1, EVAL_HIGH, EVAL_HIGH));
		chk_mot(1'b1, MAIN, 1'b1);
		sns(4'h1);
		chk_mot(1'b1, MAIN, 1'b1);
		sns(4'h2);
		chk_mot(1'b0, 16'h0, 1'b1);
		$display("test one_shut done");
	endtask
	task automatic t_level();
		sns(4'h0);
		fresh(ctrl(APP_ONE, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_HIGH, EVAL_HIGH));
		chk_mot(1'b1, MAIN, 1'b0);
		sns(4'h2);
		chk_mot(1'b0, 16'h0, 1'b0);
		sns(4'h0);
		chk_mot(1'b1, MAIN, 1'b0);
		cw(ctrl(APP_ONE, 1'b0, 1'b1, 1'b0, 1'b1, EVAL_HIGH, EVAL_HIGH));
		sns(4'h1);
		chk_mot(1'b1, MAIN, 1'b0);
		cw(ctrl(APP_ONE, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_LOW, EVAL_HIGH));
		sns(4'h3);
		chk_mot(1'b1, MAIN, 1'b0);
		sns(4'h1);
		chk_mot(1'b0, 16'h0, 1'b0);
		sns(4'h3);
		chk_mot(1'b1, MAIN, 1'b0);
		$display("test level done");
	endtask
	task automatic t_edge();
		sns(4'h0);
		fresh(ctrl(APP_ONE, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_RISE, EVAL_HIGH));
		sns(4'h1);
		chk_mot(1'b0, 16'h0, 1'b0);
		sns(4'h0);
		chk_mot(1'b0, 16'h0, 1'b0);
		fresh(ctrl(APP_ONE, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_RISE, EVAL_HIGH));
		chk_mot(1'b1, MAIN, 1'b0);
		cw(ctrl(APP_ONE, 1'b0, 1'b0, 1'b0, 1'b0, EVAL_FALL, EVAL_HIGH));
		sns(4'h1);
		cw(ctrl(APP_ONE, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_FALL, EVAL_HIGH));
		chk_mot(1'b1, MAIN, 1'b0);
		sns(4'h0);
		chk_mot(1'b0, 16'h0, 1'b0);
		$display("test edge done");
	endtask
	task automatic t_two();
		fresh(ctrl(APP_TWO, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_HIGH, EVAL_RISE));
		chk_mot(1'b1, HIGH, 1'b0);
		sns(4'h8);
		chk_mot(1'b1, LOW, 1'b0);
		sns(4'h0);
		chk_mot(1'b1, LOW, 1'b0);
		fresh(ctrl(APP_TWO, 1'b0, 1'b0, 1'b0, 1'b1, EVAL_HIGH, EVAL_HIGH));
		sns(4'h4);
		chk_mot(1'b1, LOW, 1'b0);
		sns(4'h0);
		chk_mot(1'b1, HIGH, 1'b0);
		sns(4'h2);
		chk_mot(1'b0, 16'h0, 1'b0);
		sns(4'h0);
		fresh(ctrl(APP_TWO, 1'b1, 1'b0, 1'b0, 1'b1, EVAL_HIGH, EVAL_HIGH));
		sns(4'h8);
		chk_mot(1'b1, HIGH, 1'b0);
		sns(4'h4);
		sns(4'h0);
		chk_mot(1'b1, LOW, 1'b0);
		sns(4'h2);
		chk_mot(1'b1, LOW, 1'b0);
		sns(4'h1);
		chk_mot(1'b0, 16'h0, 1'b0);
		$display("test two_speed done");
	endtask
	initial begin
		err_total = 0;
		comparisons = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		man_en = 1'b0;
		man_lvl = 4'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_motion();
		t_one_shut();
		t_level();
		t_edge();
		t_two();
		end_of_test();
	end
endmodule // lift_end_position_sequencer_bench
